// ==== rcr_pkg.sv ====
// constants, field layout and reset values of the regulator control registers
package rcr_pkg;
    // register offsets
    localparam logic [7:0] RCR_ADDR_CONV1_CONTROL = 8'h04;
    localparam logic [7:0] RCR_ADDR_CONV1_LIMIT_SLEW = 8'h05;
    localparam logic [7:0] RCR_ADDR_CONV0_VOLTAGE = 8'h06;
    localparam logic [7:0] RCR_ADDR_CONV1_VOLTAGE = 8'h07;
    localparam logic [7:0] RCR_ADDR_LIN0_CONTROL = 8'h08;
    localparam logic [7:0] RCR_ADDR_LIN1_CONTROL = 8'h09;
    localparam logic [7:0] RCR_READ_UNMAPPED = 8'h00;

    // reset values
    localparam logic [7:0] RCR_RST_CONV1_CONTROL = 8'h07;
    localparam logic [7:0] RCR_RST_CONV1_LIMIT_SLEW = 8'h1b;
    localparam logic [7:0] RCR_RST_CONV0_VOLTAGE = 8'hb1;
    localparam logic [7:0] RCR_RST_CONV1_VOLTAGE = 8'h93;
    localparam logic [7:0] RCR_RST_LIN0_CONTROL = 8'h07;
    localparam logic [7:0] RCR_RST_LIN1_CONTROL = 8'h07;

    // control register bit positions
    localparam int RCR_BIT_FORCED_PWM = 3;
    localparam int RCR_BIT_DISCHARGE = 2;
    localparam int RCR_BIT_PIN_CONTROL = 1;
    localparam int RCR_BIT_ENABLE = 0;

    // limit and slew field positions
    localparam int RCR_ILIM_MSB = 5;
    localparam int RCR_ILIM_LSB = 3;
    localparam int RCR_SLEW_MSB = 2;
    localparam int RCR_SLEW_LSB = 0;

    // current limit: 1500 mA at code 0, 500 mA per code, codes above 3 reserved
    localparam logic [2:0] RCR_ILIM_CODE_MAX = 3'h3;
    localparam logic [11:0] RCR_ILIM_BASE_MA = 12'h5dc;
    localparam logic [11:0] RCR_ILIM_STEP_MA = 12'h1f4;

    // ramp rate in uV/us per slew code, codes 0 and 1 reserved
    localparam logic [2:0] RCR_SLEW_CODE_MIN = 3'h2;
    localparam logic [13:0] RCR_RAMP_CODE2 = 14'h2710;
    localparam logic [13:0] RCR_RAMP_CODE3 = 14'h1d4c;
    localparam logic [13:0] RCR_RAMP_CODE4 = 14'h0ed8;
    localparam logic [13:0] RCR_RAMP_CODE5 = 14'h076c;
    localparam logic [13:0] RCR_RAMP_CODE6 = 14'h03ac;
    localparam logic [13:0] RCR_RAMP_CODE7 = 14'h01d6;

    // voltage code segments, outputs in mV
    localparam logic [7:0] RCR_VC_FINE_LO = 8'h14;
    localparam logic [7:0] RCR_VC_MID_LO = 8'h18;
    localparam logic [7:0] RCR_VC_COARSE_LO = 8'h9e;
    localparam logic [11:0] RCR_MV_FINE_BASE = 12'h2bc;
    localparam logic [11:0] RCR_MV_FINE_STEP = 12'h00a;
    localparam logic [11:0] RCR_MV_MID_BASE = 12'h2df;
    localparam logic [11:0] RCR_MV_MID_STEP = 12'h005;
    localparam logic [11:0] RCR_MV_COARSE_BASE = 12'h58c;
    localparam logic [11:0] RCR_MV_COARSE_STEP = 12'h014;

    // whole block state
    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic [7:0] conv1_control;
        logic [7:0] conv1_limit_and_slew;
        logic [7:0] conv0_voltage_code;
        logic [7:0] conv1_voltage_code;
        logic [7:0] lin0_control;
        logic [7:0] lin1_control;
        logic [7:0] rdata;
        logic rvalid;
        logic conv1_active;
        logic conv1_forced_pwm;
        logic conv1_discharge_on;
        logic lin0_active;
        logic lin0_discharge_on;
        logic lin1_active;
        logic lin1_discharge_on;
        logic [11:0] conv1_limit_ma;
        logic conv1_limit_reserved;
        logic [13:0] conv1_ramp_uv_us;
        logic conv1_ramp_reserved;
        logic [11:0] conv0_mv;
        logic conv0_code_reserved;
        logic [11:0] conv1_mv;
        logic conv1_code_reserved;
    } rcr_state_t;
endpackage

// ==== rcr_regulator_ctrl_regs.sv ====
// register slice steering the second converter, both converter voltages and the linear regulators
//
// Operation
// - mode bit 3: auto PFM/PWM or forced PWM
// - converter discharge resistor on only while disabled
// - pin control selects register-only or joint enable
// - converter enable bit turns converter off/on
// - current limit code 0..3 gives 1.5..3.0 A
// - current limit accepted any time while running
// - slew code 2..7 sets ramp 10..0.47 mV/us
// - codes 0x14..0x17 give 0.70..0.73 V, lower reserved
// - codes 0x18..0x9d give 0.735..1.4 V, 5 mV
// - codes 0x9e..0xff give 1.42..3.36 V, 20 mV
// - first linear discharge resistor on only while off
// - first linear pin control selects enable source
// - first linear enable bit turns it off/on
// - second linear pin control selects enable source
// - second linear enable bit turns it off/on
module rcr_regulator_ctrl_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port from the serial management interface
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // external enable pin, asynchronous
    input wire logic enable_pin,
    // second converter controls
    output logic conv1_active,
    output logic conv1_forced_pwm,
    output logic conv1_discharge_on,
    output logic [2:0] conv1_current_limit,
    output logic [11:0] conv1_limit_ma,
    output logic conv1_limit_reserved,
    output logic [2:0] conv1_ramp_rate,
    output logic [13:0] conv1_ramp_uv_us,
    output logic conv1_ramp_reserved,
    // converter voltage codes and decoded targets
    output logic [7:0] conv0_voltage_code,
    output logic [11:0] conv0_mv,
    output logic conv0_code_reserved,
    output logic [7:0] conv1_voltage_code,
    output logic [11:0] conv1_mv,
    output logic conv1_code_reserved,
    // linear regulator controls
    output logic lin0_active,
    output logic lin0_discharge_on,
    output logic lin1_active,
    output logic lin1_discharge_on
);
    import rcr_pkg::*;

    rcr_state_t s;
    rcr_state_t next_s;

    // enable resolution shared by the second converter and both linear regulators
    function automatic logic rcr_resolve_enable(input logic [7:0] ctrl, input logic pin);
        logic en_bit;
        logic pin_ctl;
        en_bit = ctrl[RCR_BIT_ENABLE];
        pin_ctl = ctrl[RCR_BIT_PIN_CONTROL];
        // register bit alone, or bit and pin together
        return pin_ctl ? (en_bit & pin) : en_bit;
    endfunction

    // discharge resistor only attached while the regulator is off
    function automatic logic rcr_discharge(input logic [7:0] ctrl, input logic active);
        return ctrl[RCR_BIT_DISCHARGE] & ~active;
    endfunction

    // voltage code to target millivolts; reserved codes give zero
    function automatic logic [11:0] rcr_code_mv(input logic [7:0] code);
        logic [11:0] cw;
        logic [11:0] mv;
        cw = {4'h0, code};
        mv = 12'h000;
        if (code < RCR_VC_FINE_LO) begin
            mv = 12'h000;
        end else if (code < RCR_VC_MID_LO) begin
            mv = RCR_MV_FINE_BASE + 12'(RCR_MV_FINE_STEP * (cw - {4'h0, RCR_VC_FINE_LO}));
        end else if (code < RCR_VC_COARSE_LO) begin
            mv = RCR_MV_MID_BASE + 12'(RCR_MV_MID_STEP * (cw - {4'h0, RCR_VC_MID_LO}));
        end else begin
            mv = RCR_MV_COARSE_BASE + 12'(RCR_MV_COARSE_STEP * (cw - {4'h0, RCR_VC_COARSE_LO}));
        end
        return mv;
    endfunction

    // slew code to ramp rate, same for rising and falling edges
    function automatic logic [13:0] rcr_ramp(input logic [2:0] code);
        logic [13:0] r;
        case (code)
            3'h2: r = RCR_RAMP_CODE2;
            3'h3: r = RCR_RAMP_CODE3;
            3'h4: r = RCR_RAMP_CODE4;
            3'h5: r = RCR_RAMP_CODE5;
            3'h6: r = RCR_RAMP_CODE6;
            3'h7: r = RCR_RAMP_CODE7;
            default: r = 14'h0000;
        endcase
        return r;
    endfunction

    // next state
    always_comb begin
        logic [2:0] ilim;
        logic [2:0] slew;
        logic act1;
        logic act_l0;
        logic act_l1;
        ilim = 3'h0;
        slew = 3'h0;
        act1 = 1'b0;
        act_l0 = 1'b0;
        act_l1 = 1'b0;
        next_s = s;

        // two-stage synchroniser for the enable pin
        next_s.pin_meta = enable_pin;
        next_s.pin_sync = s.pin_meta;

        // register writes; all bits stored as written, reserved bits included
        if (reg_write) begin
            case (reg_addr)
                RCR_ADDR_CONV1_CONTROL: next_s.conv1_control = reg_wdata;
                // no enable gating here: the limit may change mid-operation
                RCR_ADDR_CONV1_LIMIT_SLEW: next_s.conv1_limit_and_slew = reg_wdata;
                RCR_ADDR_CONV0_VOLTAGE: next_s.conv0_voltage_code = reg_wdata;
                RCR_ADDR_CONV1_VOLTAGE: next_s.conv1_voltage_code = reg_wdata;
                RCR_ADDR_LIN0_CONTROL: next_s.lin0_control = reg_wdata;
                RCR_ADDR_LIN1_CONTROL: next_s.lin1_control = reg_wdata;
                default: next_s.rdata = s.rdata; // unmapped writes are dropped
            endcase
        end

        // register reads return the stored value one cycle later
        next_s.rvalid = reg_read;
        if (reg_read) begin
            case (reg_addr)
                RCR_ADDR_CONV1_CONTROL: next_s.rdata = s.conv1_control;
                RCR_ADDR_CONV1_LIMIT_SLEW: next_s.rdata = s.conv1_limit_and_slew;
                RCR_ADDR_CONV0_VOLTAGE: next_s.rdata = s.conv0_voltage_code;
                RCR_ADDR_CONV1_VOLTAGE: next_s.rdata = s.conv1_voltage_code;
                RCR_ADDR_LIN0_CONTROL: next_s.rdata = s.lin0_control;
                RCR_ADDR_LIN1_CONTROL: next_s.rdata = s.lin1_control;
                default: next_s.rdata = RCR_READ_UNMAPPED;
            endcase
        end

        // regulator enables from registered control and synced pin
        act1 = rcr_resolve_enable(s.conv1_control, s.pin_sync);
        act_l0 = rcr_resolve_enable(s.lin0_control, s.pin_sync);
        act_l1 = rcr_resolve_enable(s.lin1_control, s.pin_sync);
        next_s.conv1_active = act1;
        next_s.lin0_active = act_l0;
        next_s.lin1_active = act_l1;

        // discharge follows the freshly resolved enable so it never overlaps drive
        next_s.conv1_discharge_on = rcr_discharge(s.conv1_control, act1);
        next_s.lin0_discharge_on = rcr_discharge(s.lin0_control, act_l0);
        next_s.lin1_discharge_on = rcr_discharge(s.lin1_control, act_l1);

        // mode: 0 auto transitions, 1 held in forced pwm
        next_s.conv1_forced_pwm = s.conv1_control[RCR_BIT_FORCED_PWM];

        // current limit decode; reserved codes flagged, limit shown as zero
        ilim = s.conv1_limit_and_slew[RCR_ILIM_MSB:RCR_ILIM_LSB];
        if (ilim > RCR_ILIM_CODE_MAX) begin
            next_s.conv1_limit_ma = 12'h000;
            next_s.conv1_limit_reserved = 1'b1;
        end else begin
            next_s.conv1_limit_ma = RCR_ILIM_BASE_MA + 12'(RCR_ILIM_STEP_MA * {9'h000, ilim});
            next_s.conv1_limit_reserved = 1'b0;
        end

        // ramp rate decode
        slew = s.conv1_limit_and_slew[RCR_SLEW_MSB:RCR_SLEW_LSB];
        next_s.conv1_ramp_uv_us = rcr_ramp(slew);
        next_s.conv1_ramp_reserved = (slew < RCR_SLEW_CODE_MIN);

        // voltage decode for both converters
        next_s.conv0_mv = rcr_code_mv(s.conv0_voltage_code);
        next_s.conv0_code_reserved = (s.conv0_voltage_code < RCR_VC_FINE_LO);
        next_s.conv1_mv = rcr_code_mv(s.conv1_voltage_code);
        next_s.conv1_code_reserved = (s.conv1_voltage_code < RCR_VC_FINE_LO);

        // reset: register defaults, everything downstream quiet
        if (rst) begin
            next_s = '0;
            next_s.conv1_control = RCR_RST_CONV1_CONTROL;
            next_s.conv1_limit_and_slew = RCR_RST_CONV1_LIMIT_SLEW;
            next_s.conv0_voltage_code = RCR_RST_CONV0_VOLTAGE;
            next_s.conv1_voltage_code = RCR_RST_CONV1_VOLTAGE;
            next_s.lin0_control = RCR_RST_LIN0_CONTROL;
            next_s.lin1_control = RCR_RST_LIN1_CONTROL;
        end
    end

    // single state register
    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // outputs straight from state flops
    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign conv1_active = s.conv1_active;
    assign conv1_forced_pwm = s.conv1_forced_pwm;
    assign conv1_discharge_on = s.conv1_discharge_on;
    assign conv1_current_limit = s.conv1_limit_and_slew[RCR_ILIM_MSB:RCR_ILIM_LSB];
    assign conv1_limit_ma = s.conv1_limit_ma;
    assign conv1_limit_reserved = s.conv1_limit_reserved;
    assign conv1_ramp_rate = s.conv1_limit_and_slew[RCR_SLEW_MSB:RCR_SLEW_LSB];
    assign conv1_ramp_uv_us = s.conv1_ramp_uv_us;
    assign conv1_ramp_reserved = s.conv1_ramp_reserved;
    assign conv0_voltage_code = s.conv0_voltage_code;
    assign conv0_mv = s.conv0_mv;
    assign conv0_code_reserved = s.conv0_code_reserved;
    assign conv1_voltage_code = s.conv1_voltage_code;
    assign conv1_mv = s.conv1_mv;
    assign conv1_code_reserved = s.conv1_code_reserved;
    assign lin0_active = s.lin0_active;
    assign lin0_discharge_on = s.lin0_discharge_on;
    assign lin1_active = s.lin1_active;
    assign lin1_discharge_on = s.lin1_discharge_on;
endmodule

// ==== rcr_regs_sva.sv ====
// concurrent checks on the regulator control register slice
module rcr_regs_sva
    import rcr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic reg_rvalid,
    // converter and regulator outputs
    input wire logic conv1_active,
    input wire logic conv1_forced_pwm,
    input wire logic conv1_discharge_on,
    input wire logic [2:0] conv1_current_limit,
    input wire logic [11:0] conv1_limit_ma,
    input wire logic conv1_limit_reserved,
    input wire logic [2:0] conv1_ramp_rate,
    input wire logic [13:0] conv1_ramp_uv_us,
    input wire logic [7:0] conv0_voltage_code,
    input wire logic [11:0] conv0_mv,
    input wire logic [7:0] conv1_voltage_code,
    input wire logic conv1_code_reserved,
    input wire logic lin0_active,
    input wire logic lin0_discharge_on
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RAMP [8] = '{0, 0, 10000, 7500, 3800, 1900, 940, 470};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // expected mV of a voltage code, 0 where reserved
    function automatic int mv_of(logic [7:0] c);
        return c < 8'h14 ? 0 : c < 8'h18 ? 700 + 10 * (c - 20) : c < 8'h9e ? 735 + 5 * (c - 24) : 1420 + 20 * (c - 158);
    endfunction
    // write steps; decoded outputs lag their codes by one flop
    sequence s_ctl_wr; reg_write && reg_addr == RCR_ADDR_CONV1_CONTROL; endsequence
    sequence s_lim_wr; reg_write && reg_addr == RCR_ADDR_CONV1_LIMIT_SLEW; endsequence
    sequence s_warm; !$past(rst); endsequence
    AST_RVALID: assert property (reg_read |=> reg_rvalid)
        else $error("read not answered in the next cycle");
    AST_RVALID_ONE: assert property (!reg_read |=> !reg_rvalid)
        else $error("read valid without a read");
    AST_PWM: assert property (s_ctl_wr |-> ##2 conv1_forced_pwm == $past(reg_wdata[3], 2))
        else $error("forced pwm does not follow the control write");
    AST_C1_DIS: assert property (conv1_discharge_on |-> !conv1_active)
        else $error("converter discharge while active");
    AST_L0_DIS: assert property (lin0_discharge_on |-> !lin0_active)
        else $error("linear discharge while active");
    AST_LIM_WR: assert property (s_lim_wr |=> conv1_current_limit == $past(reg_wdata[5:3]))
        else $error("current limit write not taken");
    AST_LIM_MA: assert property (s_warm |-> conv1_limit_ma == ($past(conv1_current_limit) > 3 ? 12'h000
        : 12'(1500 + 500 * $past(conv1_current_limit))) && conv1_limit_reserved == ($past(conv1_current_limit) > 3))
        else $error("current limit decode wrong");
    AST_RAMP: assert property (s_warm |-> conv1_ramp_uv_us == 14'(RAMP[$past(conv1_ramp_rate)]))
        else $error("ramp rate decode wrong");
    AST_MV0: assert property (s_warm |-> conv0_mv == 12'(mv_of($past(conv0_voltage_code))))
        else $error("voltage decode wrong");
    AST_RSV1: assert property (s_warm |-> conv1_code_reserved == ($past(conv1_voltage_code) < 8'h14))
        else $error("reserved voltage flag wrong");
endmodule

bind rcr_regulator_ctrl_regs rcr_regs_sva chk_u (.*);

// ==== rcr_regulator_ctrl_regs_tb.sv ====
// self-checking bench for the regulator control register slice
module rcr_regulator_ctrl_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rcr_pkg::*;
    logic clk = 1'b0;
    logic rst, reg_write, reg_read, enable_pin, act;
    logic [7:0] reg_addr, reg_wdata, a, d;
    logic [7:0] reg_rdata, conv0_voltage_code, conv1_voltage_code;
    logic reg_rvalid, conv1_active, conv1_forced_pwm, conv1_discharge_on, conv1_limit_reserved;
    logic conv1_ramp_reserved, conv0_code_reserved, conv1_code_reserved;
    logic lin0_active, lin0_discharge_on, lin1_active, lin1_discharge_on;
    logic [2:0] conv1_current_limit, conv1_ramp_rate;
    logic [11:0] conv1_limit_ma, conv0_mv, conv1_mv;
    logic [13:0] conv1_ramp_uv_us;
    logic [7:0] m [16];
    int seed = 44;
    int fails = 0;
    int total_checks = 0;
    int rt [8] = '{0, 0, 10000, 7500, 3800, 1900, 940, 470};

    rcr_regulator_ctrl_regs dut_u (.*);

    // 250 MHz clock
    always #2 clk = ~clk;

    // model of the voltage code decode
    function automatic int emv(int c);
        if (c < 20) return 0;
        if (c < 24) return 700 + 10 * (c - 20);
        if (c < 158) return 735 + 5 * (c - 24);
        return 1420 + 20 * (c - 158);
    endfunction

    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one write; returns once decoded outputs have settled
    task automatic wr(logic [7:0] wa, logic [7:0] wd);
        reg_addr = wa;
        reg_wdata = wd;
        reg_write = 1'b1;
        if (wa >= 8'h04 && wa <= 8'h09) m[wa[3:0]] = wd;
        @(posedge clk);
        #1 reg_write = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // one read, compared with the model; unmapped places read zero
    task automatic rd(logic [7:0] ra);
        reg_addr = ra;
        reg_read = 1'b1;
        @(posedge clk);
        #1 reg_read = 1'b0;
        chk("rvalid", reg_rvalid, 1);
        chk("rdata", reg_rdata, ra < 16 ? m[ra[3:0]] : 8'h00);
        @(posedge clk);
        #1 chk("rvalid pulse", reg_rvalid, 0);
    endtask

    task automatic do_reset();
        rst = 1'b1;
        m = '{default: 8'h00};
        m[4] = 8'h07;
        m[5] = 8'h1b;
        m[6] = 8'hb1;
        m[7] = 8'h93;
        m[8] = 8'h07;
        m[9] = 8'h07;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {reg_write, reg_read, enable_pin, reg_addr, reg_wdata} = '0;
        do_reset();
        for (int i = 0; i < 16; i++) rd(i[7:0]);
        wr(8'h0c, 8'h5a);
        rd(8'h0c);
        rd(8'hf3);
        $display("test defaults done");
        // every voltage code on both converters
        for (int c = 0; c < 256; c++) begin
            wr(8'h06, c[7:0]);
            wr(8'h07, 8'(255 - c));
            chk("conv0_mv", conv0_mv, emv(c));
            chk("conv1_mv", conv1_mv, emv(255 - c));
            chk("conv0_rsv", conv0_code_reserved, c < 20);
            chk("conv1_rsv", conv1_code_reserved, (255 - c) < 20);
            chk("conv0_code", conv0_voltage_code, c);
            chk("conv1_code", conv1_voltage_code, 255 - c);
        end
        $display("test voltage done");
        // every limit and slew code while the converter runs
        wr(8'h04, 8'h05);
        for (int c = 0; c < 64; c++) begin
            wr(8'h05, c[7:0]);
            chk("limit_ma", conv1_limit_ma, c[5:3] > 3 ? 0 : 1500 + 500 * c[5:3]);
            chk("limit_rsv", conv1_limit_reserved, c[5:3] > 3);
            chk("ramp", conv1_ramp_uv_us, rt[c[2:0]]);
            chk("ramp_rsv", conv1_ramp_reserved, c[2:0] < 2);
            chk("ilim_code", conv1_current_limit, c[5:3]);
            chk("slew_code", conv1_ramp_rate, c[2:0]);
            chk("running", conv1_active, 1);
        end
        $display("test limit done");
        // every control setting against both pin levels
        for (int v = 0; v < 32; v++) begin
            enable_pin = v[4];
            wr(8'h04, 8'(v[3:0]));
            wr(8'h08, 8'(v[2:0]));
            wr(8'h09, 8'(v[2:0]));
            repeat (3) @(posedge clk);
            #1 act = v[0] & (!v[1] | v[4]);
            chk("conv1_active", conv1_active, act);
            chk("conv1_dis", conv1_discharge_on, v[2] & !act);
            chk("pwm", conv1_forced_pwm, v[3]);
            chk("lin0_active", lin0_active, act);
            chk("lin0_dis", lin0_discharge_on, v[2] & !act);
            chk("lin1_active", lin1_active, act);
            chk("lin1_dis", lin1_discharge_on, v[2] & !act);
        end
        $display("test enable done");
        // random register traffic, reserved bits kept zero
        for (int i = 0; i < 40; i++) begin
            a = 8'($random(seed)) & 8'h0f;
            d = 8'($random(seed));
            // keep reserved codes and reserved upper bits out of every write
            case (a)
                8'h05: d = {3'b000, d[4:3], 3'(d[2:0] % 3'h6 + 3'h2)};
                8'h06, 8'h07: d = (d < 8'h14) ? d + 8'h14 : d;
                8'h08, 8'h09: d = d & 8'h07;
                default: d = d & 8'h0f;
            endcase
            wr(a, d);
            rd(a);
        end
        $display("test random done");
        // reset in mid run restores defaults
        do_reset();
        for (int i = 4; i < 10; i++) rd(i[7:0]);
        chk("limit_ma", conv1_limit_ma, 3000);
        chk("ramp", conv1_ramp_uv_us, 7500);
        chk("conv0_mv", conv0_mv, emv(8'hb1));
        chk("conv1_mv", conv1_mv, emv(8'h93));
        $display("test reset done");
        end_of_test();
    end

    // hang guard, far beyond the expected run
    initial begin
        #400000;
        fails++;
        end_of_test();
    end
endmodule
